// *** hw/module_power_reset_sequencer.sv ***
// Power and reset sequencer at the module end of the power-key link.
// Assumes key and reset lines are synchronous to sys_clk_i and that the
// key line reads high when nobody pulls it low.
module module_power_reset_sequencer (
    input  wire logic           sys_clk_i,
    input  wire logic           nrst_i,
    pwr_seq_if.module_end       link,
    input  wire logic           supply_ok_i,
    input  wire logic           over_temp_i,
    input  wire logic           off_cmd_i,
    input  wire logic           soft_reset_i,
    input  wire logic           save_done_i,
    output logic                core_rst_n_o,
    output logic                save_req_o,
    output logic                abrupt_off_o
);
    // ****************************************
    // State and press classification
    // ****************************************
    typedef enum logic [6:0] {
        ST_OFF   = 7'b0000001,
        ST_SUP   = 7'b0000010,
        ST_RST   = 7'b0000100,
        ST_PINS  = 7'b0001000,
        ST_READY = 7'b0010000,
        ST_SAVE  = 7'b0100000,
        ST_DOWN  = 7'b1000000
    } state_e;

    state_e                                 state;
    state_e                                 next_state;
    logic [pwr_seq_pkg::CNT_W-1:0]          press_cnt;
    logic [15:0]                            timer;
    logic [$clog2(pwr_seq_pkg::NUM_PINS):0] pin_idx;
    logic                                   reboot;
    logic                                   io_supply;
    logic [pwr_seq_pkg::NUM_PINS-1:0]       pin_oe;
    logic                                   rdy;

    wire key_low        = link.key_low_oe;
    wire hw_reset       = io_supply & link.reset_low_oe;
    wire press_valid    = press_cnt >= pwr_seq_pkg::CNT_W'(pwr_seq_pkg::KEY_VALID_CYC);
    wire press_emerg    = press_cnt >= pwr_seq_pkg::CNT_W'(pwr_seq_pkg::KEY_EMERG_CYC);
    wire key_released   = !key_low && press_valid && !press_emerg;
    wire timer_done     = timer == 16'h0000;
    wire pins_done      = pin_idx == ($clog2(pwr_seq_pkg::NUM_PINS)+1)'(pwr_seq_pkg::NUM_PINS);
    wire abrupt         = !supply_ok_i || over_temp_i || (key_low && press_emerg);
    wire on_state       = state != ST_OFF;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF:   if (supply_ok_i && key_released) next_state = ST_SUP;
            ST_SUP:   next_state = ST_RST;
            ST_RST:   if (timer_done) next_state = ST_PINS;
            ST_PINS:  if (pins_done) next_state = ST_READY;
            ST_READY: if (off_cmd_i || soft_reset_i || key_released) next_state = ST_SAVE;
            ST_SAVE:  if (save_done_i) next_state = ST_DOWN;
            ST_DOWN:  next_state = reboot ? ST_SUP : ST_OFF;
            default:  next_state = ST_OFF;
        endcase
        if (on_state && hw_reset) next_state = ST_SUP;
        if (on_state && abrupt) next_state = ST_OFF;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            press_cnt <= '0;
        end else if (!key_low) begin
            press_cnt <= '0;
        end else if (press_cnt != '1) begin
            press_cnt <= press_cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer   <= 16'h0000;
            pin_idx <= '0;
        end else if (next_state == ST_RST && state != ST_RST) begin
            timer   <= pwr_seq_pkg::RST_HOLD_CYC;
            pin_idx <= '0;
        end else if (state == ST_RST) begin
            timer   <= timer_done ? 16'h0000 : timer - 16'h0001;
        end else if (state == ST_PINS) begin
            timer   <= timer_done ? pwr_seq_pkg::PIN_STEP_CYC : timer - 16'h0001;
            if (timer_done && !pins_done) begin
                pin_idx <= pin_idx + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reboot <= 1'b0;
        end else if (state == ST_READY) begin
            reboot <= soft_reset_i && !off_cmd_i;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Supply follows on state.
    wire next_io_supply = next_state != ST_OFF;
    // Core reset held until pins phase.
    wire next_core_rst_n = next_state == ST_PINS || next_state == ST_READY || next_state == ST_SAVE;
    logic [pwr_seq_pkg::NUM_PINS-1:0] next_pin_oe;
    always_comb begin
        next_pin_oe = '0;
        for (int i = 0; i < pwr_seq_pkg::NUM_PINS; i++) begin
            next_pin_oe[i] = (next_state == ST_PINS && i < int'(pin_idx))
                           || next_state == ST_READY || next_state == ST_SAVE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            io_supply    <= 1'b0;
            core_rst_n_o <= 1'b0;
            pin_oe       <= '0;
            rdy          <= 1'b0;
            save_req_o   <= 1'b0;
            abrupt_off_o <= 1'b0;
        end else begin
            io_supply    <= next_io_supply;
            core_rst_n_o <= next_core_rst_n;
            pin_oe       <= next_pin_oe;
            rdy          <= next_state == ST_READY;
            save_req_o   <= next_state == ST_SAVE;
            abrupt_off_o <= on_state && (abrupt || hw_reset);
        end
    end

    assign link.io_supply_on = io_supply;
    assign link.pin_oe       = pin_oe;
    assign link.ready        = rdy;
endmodule

// *** shared/pwr_seq_pkg.sv ***
// Constants shared by the module-side sequencer and the host-side controller.
// Assumes one 40 MHz clock common to both ends.
package pwr_seq_pkg;
    localparam int unsigned CLK_HZ            = 40_000_000;
    // Switch-on and normal switch-off press, in microseconds.
    localparam int unsigned KEY_VALID_US      = 50;
    // Emergency press, in microseconds.
    localparam int unsigned KEY_EMERG_US      = 1000;
    localparam int unsigned KEY_VALID_CYC     = (KEY_VALID_US * (CLK_HZ / 1_000_000));
    localparam int unsigned KEY_EMERG_CYC     = (KEY_EMERG_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CNT_W             = 16;
    localparam logic [15:0] RST_HOLD_CYC      = 16'h0010;
    localparam logic [15:0] PIN_STEP_CYC      = 16'h0004;
    localparam int unsigned NUM_PINS          = 4;
    localparam logic [15:0] HOST_GUARD_CYC    = 16'h0008;
endpackage

// *** shared/pwr_seq_if.sv ***
// Pin-level link between host controller and module sequencer.
// Assumes the testbench resolves the open-drain key line from the enables.
interface pwr_seq_if;
    logic                       key_low_oe;
    logic                       reset_low_oe;
    logic                       io_supply_on;
    logic [pwr_seq_pkg::NUM_PINS-1:0] pin_oe;
    logic                       ready;
    modport module_end (
        input  key_low_oe,
        input  reset_low_oe,
        output io_supply_on,
        output pin_oe,
        output ready
    );
    modport host_end (
        output key_low_oe,
        output reset_low_oe,
        input  io_supply_on,
        input  pin_oe,
        input  ready
    );
endinterface

// *** hw/host_power_controller.sv ***
// Host-side controller that drives the power key and reset lines.
// Assumes the module end shares sys_clk_i.
module host_power_controller (
    input  wire logic           sys_clk_i,
    input  wire logic           nrst_i,
    pwr_seq_if.host_end         link,
    input  wire logic           press_i,
    input  wire logic           emerg_i,
    input  wire logic           hw_reset_i,
    output logic                can_cmd_o,
    output logic                can_cut_supply_o,
    output logic                pin_drive_o
);
    logic [15:0] cnt;
    logic        key_oe;
    logic        rst_oe;

    wire [15:0] press_len = emerg_i ? 16'(pwr_seq_pkg::KEY_EMERG_CYC + 8) : 16'(pwr_seq_pkg::KEY_VALID_CYC + 4);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt    <= 16'h0000;
            key_oe <= 1'b0;
        end else if (cnt != 16'h0000) begin
            cnt    <= cnt - 16'h0001;
            key_oe <= cnt != 16'h0001;
        end else if (press_i || emerg_i) begin
            cnt    <= press_len;
            key_oe <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_oe           <= 1'b0;
            can_cmd_o        <= 1'b0;
            can_cut_supply_o <= 1'b1;
            pin_drive_o      <= 1'b0;
        end else begin
            rst_oe           <= hw_reset_i;
            can_cmd_o        <= link.ready;
            // Cut supply after IO supply low.
            can_cut_supply_o <= !link.io_supply_on;
            // Drive pins only with IO supply.
            pin_drive_o      <= link.io_supply_on && link.ready;
        end
    end

    assign link.key_low_oe   = key_oe;
    assign link.reset_low_oe = rst_oe;
endmodule

// *** verification/pwr_seq_chk.sv ***
// Checker of the pin-level power-key link.
// Assumes one clock shared by both ends and an active-low reset.
module pwr_seq_chk (
    input  wire logic                         sys_clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         key_low_oe,
    input  wire logic                         reset_low_oe,
    input  wire logic                         io_supply_on,
    input  wire logic [pwr_seq_pkg::NUM_PINS-1:0] pin_oe,
    input  wire logic                         ready
);
    // ************
    // Link checks.
    // ************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_pins_need_io: assert property ((|pin_oe) |-> io_supply_on)
        else $error("pins driven without io supply");
    a_ready_all_pins: assert property (ready |-> (&pin_oe))
        else $error("ready before all pins");
    a_off_all_idle: assert property (!io_supply_on |-> !ready && !(|pin_oe))
        else $error("pins or ready while off");
    a_pin_order: assert property ($changed(pin_oe) && (|pin_oe)
        |-> pin_oe == {$past(pin_oe[pwr_seq_pkg::NUM_PINS-2:0]), 1'b1})
        else $error("pins released out of order");
    a_core_reset_hold: assert property ($rose(io_supply_on)
        |=> (!(|pin_oe))[*8] ##[9:60] pin_oe[0])
        else $error("pin release timing wrong");
    a_pin_step: assert property ($rose(pin_oe[0]) |-> ##5 pin_oe[1])
        else $error("pin step spacing wrong");
    a_on_after_release: assert property ($rose(io_supply_on) |-> !key_low_oe)
        else $error("io supply on while key low");
    a_press_held: assert property ($rose(key_low_oe) |=> key_low_oe[*8])
        else $error("key press too short");
    c_power_on: cover property ($rose(ready));
    c_power_off: cover property ($fell(io_supply_on));
    c_hw_reset: cover property ($rose(reset_low_oe));
endmodule

// *** verification/tb.sv ***
// Testbench joining host controller and module sequencer.
// Assumes the shared package and interface are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       sup = 1'b0, hot = 1'b0, off = 1'b0, srst = 1'b0, sdone = 1'b0;
    logic       press = 1'b0, emerg = 1'b0, hwr = 1'b0;
    logic       core_n, save, abrupt, can_cmd, can_cut, pdrv;
    logic [7:0] lfsr = 8'h44;
    int         bad_count = 0;
    int         n_checks = 0;
    int         n_abrupt = 0;
    int         k;
    pwr_seq_if  lk ();
    module_power_reset_sequencer module_power_reset_sequencer_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .link(lk), .supply_ok_i(sup), .over_temp_i(hot), .off_cmd_i(off), .soft_reset_i(srst),
        .save_done_i(sdone), .core_rst_n_o(core_n), .save_req_o(save), .abrupt_off_o(abrupt));
    host_power_controller host_power_controller_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .link(lk),
        .press_i(press), .emerg_i(emerg), .hw_reset_i(hwr), .can_cmd_o(can_cmd),
        .can_cut_supply_o(can_cut), .pin_drive_o(pdrv));
    pwr_seq_chk pwr_seq_chk_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .key_low_oe(lk.key_low_oe),
        .reset_low_oe(lk.reset_low_oe), .io_supply_on(lk.io_supply_on), .pin_oe(lk.pin_oe),
        .ready(lk.ready));
    // ******************
    // Helpers and checks.
    // ******************
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (abrupt === 1'b1) n_abrupt++;
    function logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    task chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task chk4(input logic [pwr_seq_pkg::NUM_PINS-1:0] got, input logic [pwr_seq_pkg::NUM_PINS-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask
    task wait_st(input bit rdy, input logic v);
        int i;
        for (i = 0; i < 4000 && (rdy ? lk.ready : lk.io_supply_on) !== v; i++) tick(1);
        chk1(rdy ? lk.ready : lk.io_supply_on, v);
    endtask
    task power_on(input bit on = 1'b1);
        press = 1'b1;
        tick(1);
        press = 1'b0;
        if (!on) begin
            tick(pwr_seq_pkg::KEY_VALID_CYC + 40);
            chk1(lk.ready, 1'b0);
            return;
        end
        wait_st(1, 1'b1);
        chk1(core_n, 1'b1);
        chk4(lk.pin_oe, 4'hf);
        tick(2);
        chk1(can_cmd, 1'b1);
        chk1(pdrv, 1'b1);
    endtask
    task finish_save(input bit reboot);
        int i;
        for (i = 0; i < 4000 && save !== 1'b1; i++) tick(1);
        chk1(save, 1'b1);
        tick(1 + lfsr[3:0]);
        lfsr = next_rand(lfsr);
        chk1(lk.io_supply_on, 1'b1);
        sdone = 1'b1;
        wait_st(1, 1'b0);
        if (reboot) wait_st(1, 1'b1);
        else wait_st(0, 1'b0);
        sdone = 1'b0;
        tick(2);
        if (!reboot) chk4(lk.pin_oe, 4'h0);
        if (!reboot) chk1(can_cut, 1'b1);
        if (!reboot) chk1(pdrv, 1'b0);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(25 * 90000);
        bad_count++;
        end_sim();
    end
    initial begin
        tick(20);
        nrst_i = 1'b1;
        tick(1);
        power_on(1'b0);
        chk1(lk.io_supply_on, 1'b0);
        sup = 1'b1;
        tick(50);
        chk1(lk.io_supply_on, 1'b0);
        $display("test refuse done");
        power_on();
        off = 1'b1;
        tick(1);
        off = 1'b0;
        finish_save(0);
        power_on();
        press = 1'b1;
        tick(1);
        press = 1'b0;
        finish_save(0);
        power_on();
        srst = 1'b1;
        tick(1);
        srst = 1'b0;
        finish_save(1);
        $display("test normal off done");
        hwr = 1'b1;
        tick(4);
        chk1(core_n, 1'b0);
        chk1(save, 1'b0);
        hwr = 1'b0;
        wait_st(1, 1'b1);
        for (k = 0; k < 2; k++) begin
            if (k == 1) power_on();
            n_abrupt = 0;
            hot = (k == 0);
            sup = (k == 1) ? 1'b0 : 1'b1;
            tick(3);
            chk1(lk.io_supply_on, 1'b0);
            chk1(save, 1'b0);
            chk1(n_abrupt > 0, 1'b1);
            hot = 1'b0;
            sup = 1'b1;
            tick(50);
            chk1(lk.io_supply_on, 1'b0);
        end
        $display("test abrupt done");
        power_on();
        emerg = 1'b1;
        tick(1);
        emerg = 1'b0;
        tick(pwr_seq_pkg::KEY_EMERG_CYC - 100);
        chk1(lk.io_supply_on, 1'b1);
        tick(200);
        chk1(lk.io_supply_on, 1'b0);
        chk1(save, 1'b0);
        tick(50);
        chk1(lk.io_supply_on, 1'b0);
        $display("test emergency done");
        end_sim();
    end
endmodule
